/* hw/scuwp_core_host.sv */
/*
 * Core end: turns user operations into register port traffic, building the
 * password command sequences from the status register it reads first.
 * Assumes the device answers a read one cycle after the strobe.
 */
`timescale 1ns/10ps
`include "scuwp_consts.svh"

module scuwp_core_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    scuwp_if.host core,
    // User request
    input wire logic op_start,
    input wire scuwp_pkg::scuwp_op_t op_kind,
    input wire logic [15:0] op_addr,
    input wire logic [15:0] op_data,
    input wire logic [1:0] op_level,
    input wire logic [7:0] op_pwd,
    // User answer
    output logic op_busy,
    output logic op_done,
    output logic op_refused,
    output logic [15:0] op_rdata
);

    scuwp_pkg::scuwp_host_t st_q;
    scuwp_pkg::scuwp_op_t kind_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic [1:0] lvl_q;
    logic [7:0] newpwd_q;
    logic [7:0] curpwd_q;
    logic [2:0] idx_q;
    logic [2:0] cnt_q;
    logic init_done_q;
    logic [15:0] wa_q;
    logic [15:0] wd_q;
    logic wr_q;
    logic rd_q;
    logic eoi_q;
    logic busy_q;
    logic done_q;
    logic refused_q;
    logic [15:0] rdata_q;
    logic [1:0] cur_sl;
    logic prot_addr;

    function automatic logic is_prot(input logic [15:0] a);
        return a == `SCUWP_ADDR_CFG1 || a == `SCUWP_ADDR_CFG2 || a == `SCUWP_ADDR_CFG3;
    endfunction

    assign cur_sl = core.core_rdata[`SCUWP_ST_SL_LSB +: 2];
    assign prot_addr = is_prot(addr_q);

    // Sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= scuwp_pkg::H_IDLE;
            kind_q <= scuwp_pkg::OP_READ;
            addr_q <= `SCUWP_ZERO16;
            data_q <= `SCUWP_ZERO16;
            lvl_q <= `SCUWP_SL_UNPROT;
            newpwd_q <= `SCUWP_PWD_RST;
            curpwd_q <= `SCUWP_PWD_RST;
            idx_q <= 3'h0;
            cnt_q <= 3'h0;
            init_done_q <= 1'b0;
            wa_q <= `SCUWP_ZERO16;
            wd_q <= `SCUWP_ZERO16;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            eoi_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q <= `SCUWP_ZERO16;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            eoi_q <= 1'b0;
            done_q <= 1'b0;
            case (st_q)
                scuwp_pkg::H_IDLE: begin
                    if (op_start) begin
                        kind_q <= op_kind;
                        addr_q <= op_addr;
                        data_q <= op_data;
                        lvl_q <= op_level;
                        newpwd_q <= op_pwd;
                        busy_q <= 1'b1;
                        refused_q <= 1'b0;
                        idx_q <= 3'h0;
                        if (op_kind == scuwp_pkg::OP_END_INIT) begin
                            eoi_q <= 1'b1;
                            init_done_q <= 1'b1;
                            st_q <= scuwp_pkg::H_DONE;
                        end else if (op_kind == scuwp_pkg::OP_READ) begin
                            wa_q <= op_addr;
                            rd_q <= 1'b1;
                            st_q <= scuwp_pkg::H_READ_WAIT;
                        end else if (op_kind == scuwp_pkg::OP_WRITE &&
                                     op_addr == `SCUWP_ADDR_VIS && init_done_q) begin
                            // Visibility is settled before init ends
                            refused_q <= 1'b1;
                            st_q <= scuwp_pkg::H_DONE;
                        end else begin
                            st_q <= scuwp_pkg::H_STAT_RD;
                        end
                    end
                end
                scuwp_pkg::H_STAT_RD: begin
                    wa_q <= `SCUWP_ADDR_STAT;
                    rd_q <= 1'b1;
                    st_q <= scuwp_pkg::H_STAT_WAIT;
                end
                scuwp_pkg::H_STAT_WAIT: begin
                    if (core.core_rvalid) begin
                        curpwd_q <= core.core_rdata[`SCUWP_ST_PWD_LSB +: 8];
                        if (kind_q == scuwp_pkg::OP_SET_LEVEL) begin
                            cnt_q <= 3'h4;
                            idx_q <= 3'h0;
                        end else if (prot_addr && cur_sl == `SCUWP_SL_LOW) begin
                            cnt_q <= 3'h2;
                            idx_q <= 3'h0;
                        end else begin
                            cnt_q <= 3'h2;
                            idx_q <= 3'h1;
                        end
                        st_q <= scuwp_pkg::H_WRITE;
                    end
                end
                scuwp_pkg::H_WRITE: begin
                    wr_q <= 1'b1;
                    if (kind_q == scuwp_pkg::OP_SET_LEVEL) begin
                        wa_q <= `SCUWP_ADDR_CMD;
                        case (idx_q)
                            3'h0: wd_q <= `SCUWP_CMD0_WORD;
                            3'h1: wd_q <= `SCUWP_CMD1_WORD;
                            3'h2: wd_q <= {`SCUWP_CMD2_HI, ~curpwd_q};
                            default: wd_q <= {`SCUWP_C3_ZERO3, lvl_q, `SCUWP_C3_ZERO3, newpwd_q};
                        endcase
                    end else if (idx_q == 3'h0) begin
                        wa_q <= `SCUWP_ADDR_CMD;
                        wd_q <= {`SCUWP_UNLOCK_HI, ~curpwd_q};
                    end else if (addr_q == `SCUWP_ADDR_VIS) begin
                        wa_q <= addr_q;
                        wd_q <= data_q & `SCUWP_VIS_WMASK;
                    end else begin
                        wa_q <= addr_q;
                        wd_q <= data_q;
                    end
                    idx_q <= idx_q + 3'h1;
                    if (idx_q + 3'h1 == cnt_q) begin
                        st_q <= scuwp_pkg::H_DONE;
                    end
                end
                scuwp_pkg::H_READ_WAIT: begin
                    if (core.core_rvalid) begin
                        rdata_q <= core.core_rdata;
                        st_q <= scuwp_pkg::H_DONE;
                    end
                end
                default: begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    st_q <= scuwp_pkg::H_IDLE;
                end
            endcase
        end
    end

    assign core.core_addr = wa_q;
    assign core.core_wdata = wd_q;
    assign core.core_wr = wr_q;
    assign core.core_rd = rd_q;
    assign core.end_of_init = eoi_q;
    assign op_busy = busy_q;
    assign op_done = done_q;
    assign op_refused = refused_q;
    assign op_rdata = rdata_q;

endmodule

/* hw/scuwp_device.sv */
/*
 * System control unit end: peripheral visibility register, security level
 * state machine and the three write-protected system configuration
 * registers. Assumes a core that issues one-cycle read/write strobes on a
 * 16-bit register port, and a one-cycle end_of_init pulse.
 */
`timescale 1ns/10ps
`include "scuwp_consts.svh"

module scuwp_device (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Core register port
    scuwp_if.dev core,
    // System side
    output logic [15:0] sys_cfg1,
    output logic [15:0] sys_cfg2,
    output logic [15:0] sys_cfg3,
    output logic [1:0] security_level,
    output logic [2:0] cmd_state
);

    scuwp_pkg::scuwp_seq_t st_q;
    logic [1:0] level_q;
    logic [7:0] pwd_q;
    logic [15:0] vis_q;
    logic [15:0] cfg1_q;
    logic [15:0] cfg2_q;
    logic [15:0] cfg3_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic prot_ok;
    logic cmd_wr;
    logic [2:0] st_code;
    logic [2:0] cmd_state_q;

    function automatic logic [2:0] state_code(input scuwp_pkg::scuwp_seq_t s);
        logic [2:0] c;
        c = `SCUWP_STC_CMD0;
        case (s)
            scuwp_pkg::SEQ_CMD1: c = `SCUWP_STC_CMD1;
            scuwp_pkg::SEQ_CMD2: c = `SCUWP_STC_CMD2;
            scuwp_pkg::SEQ_CMD3: c = `SCUWP_STC_CMD3;
            scuwp_pkg::SEQ_UNLOCKED: c = `SCUWP_STC_UNLOCK;
            default: c = `SCUWP_STC_CMD0;
        endcase
        return c;
    endfunction

    function automatic logic [15:0] pwd_word(input logic [7:0] hi, input logic [7:0] pwd);
        return {hi, ~pwd};
    endfunction

    assign st_code = state_code(st_q);
    assign cmd_wr = core.core_wr && (core.core_addr == `SCUWP_ADDR_CMD);

    // Write permission for the protectable configuration registers
    always_comb begin
        case (level_q)
            `SCUWP_SL_UNPROT: prot_ok = 1'b1;
            `SCUWP_SL_LOW: prot_ok = (st_q == scuwp_pkg::SEQ_UNLOCKED);
            default: prot_ok = 1'b0;
        endcase
    end

    // Security level state machine; reads never reach it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= scuwp_pkg::SEQ_CMD0;
            level_q <= `SCUWP_SL_UNPROT;
            pwd_q <= `SCUWP_PWD_RST;
        end else if (core.end_of_init) begin
            level_q <= `SCUWP_SL_WPROT;
            st_q <= scuwp_pkg::SEQ_CMD0;
        end else if (cmd_wr) begin
            case (st_q)
                scuwp_pkg::SEQ_CMD0: begin
                    if (core.core_wdata == `SCUWP_CMD0_WORD) begin
                        st_q <= scuwp_pkg::SEQ_CMD1;
                    end else if (level_q == `SCUWP_SL_LOW &&
                                 core.core_wdata == pwd_word(`SCUWP_UNLOCK_HI, pwd_q)) begin
                        st_q <= scuwp_pkg::SEQ_UNLOCKED;
                    end else begin
                        st_q <= scuwp_pkg::SEQ_CMD0;
                    end
                end
                scuwp_pkg::SEQ_CMD1: begin
                    if (core.core_wdata == `SCUWP_CMD1_WORD) begin
                        st_q <= scuwp_pkg::SEQ_CMD2;
                    end else begin
                        st_q <= scuwp_pkg::SEQ_CMD0;
                    end
                end
                scuwp_pkg::SEQ_CMD2: begin
                    if (core.core_wdata == pwd_word(`SCUWP_CMD2_HI, pwd_q)) begin
                        st_q <= scuwp_pkg::SEQ_CMD3;
                    end else begin
                        st_q <= scuwp_pkg::SEQ_CMD0;
                    end
                end
                scuwp_pkg::SEQ_CMD3: begin
                    // Reserved level code or nonzero filler bits reject the command
                    if (core.core_wdata[`SCUWP_C3_Z1_MSB:`SCUWP_C3_Z1_LSB] == `SCUWP_C3_ZERO3 &&
                        core.core_wdata[`SCUWP_C3_Z2_MSB:`SCUWP_C3_Z2_LSB] == `SCUWP_C3_ZERO3 &&
                        core.core_wdata[`SCUWP_C3_SL_MSB:`SCUWP_C3_SL_LSB] != `SCUWP_SL_RSVD) begin
                        level_q <= core.core_wdata[`SCUWP_C3_SL_MSB:`SCUWP_C3_SL_LSB];
                        pwd_q <= core.core_wdata[7:0];
                    end
                    st_q <= scuwp_pkg::SEQ_CMD0;
                end
                default: begin
                    st_q <= scuwp_pkg::SEQ_CMD0;
                end
            endcase
        end else if (core.core_wr && st_q == scuwp_pkg::SEQ_UNLOCKED) begin
            st_q <= scuwp_pkg::SEQ_CMD0;
        end
    end

    // Peripheral visibility register, not protectable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vis_q <= `SCUWP_VIS_RST;
        end else if (core.core_wr && core.core_addr == `SCUWP_ADDR_VIS) begin
            vis_q <= core.core_wdata;
        end
    end

    // Protectable system configuration registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg1_q <= `SCUWP_CFG_RST;
            cfg2_q <= `SCUWP_CFG_RST;
            cfg3_q <= `SCUWP_CFG_RST;
        end else if (core.core_wr && prot_ok && !core.end_of_init) begin
            if (core.core_addr == `SCUWP_ADDR_CFG1) begin
                cfg1_q <= core.core_wdata;
            end else if (core.core_addr == `SCUWP_ADDR_CFG2) begin
                cfg2_q <= core.core_wdata;
            end else if (core.core_addr == `SCUWP_ADDR_CFG3) begin
                cfg3_q <= core.core_wdata;
            end
        end
    end

    // Read decode; the status register is read-only and writes to it are dropped
    always_comb begin
        rdata_d = `SCUWP_ZERO16;
        if (core.core_addr == `SCUWP_ADDR_VIS) begin
            rdata_d = vis_q;
        end else if (core.core_addr == `SCUWP_ADDR_STAT) begin
            rdata_d[`SCUWP_ST_PWD_LSB +: 8] = pwd_q;
            rdata_d[`SCUWP_ST_SL_LSB +: 2] = level_q;
            rdata_d[`SCUWP_ST_STATE_LSB +: 3] = st_code;
        end else if (core.core_addr == `SCUWP_ADDR_CFG1) begin
            rdata_d = cfg1_q;
        end else if (core.core_addr == `SCUWP_ADDR_CFG2) begin
            rdata_d = cfg2_q;
        end else if (core.core_addr == `SCUWP_ADDR_CFG3) begin
            rdata_d = cfg3_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= `SCUWP_ZERO16;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= core.core_rd;
            if (core.core_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Registered copy of the state code for the output pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_state_q <= `SCUWP_STC_CMD0;
        end else begin
            cmd_state_q <= st_code;
        end
    end

    assign core.core_rdata = rdata_q;
    assign core.core_rvalid = rvalid_q;
    // Each enable gates one peripheral; bit five is the terminal bus module
    assign core.periph_visible = vis_q;
    assign sys_cfg1 = cfg1_q;
    assign sys_cfg2 = cfg2_q;
    assign sys_cfg3 = cfg3_q;
    assign security_level = level_q;
    assign cmd_state = cmd_state_q;

endmodule

/* include/scuwp_consts.svh */
/*
 * Constants of the system control write protection and peripheral
 * visibility block: register addresses, field positions, reset values and
 * command patterns. Assumes a 16-bit register port driven by the core.
 */
`ifndef SCUWP_CONSTS_SVH
`define SCUWP_CONSTS_SVH

// Register addresses on the core register port
`define SCUWP_ADDR_VIS 16'hf024
`define SCUWP_ADDR_CMD 16'hf0c0
`define SCUWP_ADDR_STAT 16'hf0c2
`define SCUWP_ADDR_CFG1 16'hf1dc
`define SCUWP_ADDR_CFG2 16'hf1d0
`define SCUWP_ADDR_CFG3 16'hf1d4

// Reset values
`define SCUWP_VIS_RST 16'h0000
`define SCUWP_CFG_RST 16'h0000
`define SCUWP_PWD_RST 8'h00
`define SCUWP_ZERO16 16'h0000

// Visibility bits software may set
`define SCUWP_VIS_WMASK 16'h0020
`define SCUWP_VIS_TERM_BIT 5

// Security level codes
`define SCUWP_SL_UNPROT 2'h0
`define SCUWP_SL_LOW 2'h1
`define SCUWP_SL_RSVD 2'h2
`define SCUWP_SL_WPROT 2'h3

// Command patterns
`define SCUWP_CMD0_WORD 16'haaaa
`define SCUWP_CMD1_WORD 16'h5554
`define SCUWP_CMD2_HI 8'h96
`define SCUWP_UNLOCK_HI 8'h8e

// Command 3 layout: zeros, level, zeros, password
`define SCUWP_C3_Z1_MSB 15
`define SCUWP_C3_Z1_LSB 13
`define SCUWP_C3_SL_MSB 12
`define SCUWP_C3_SL_LSB 11
`define SCUWP_C3_Z2_MSB 10
`define SCUWP_C3_Z2_LSB 8
`define SCUWP_C3_ZERO3 3'h0

// Status register layout
`define SCUWP_ST_PWD_LSB 0
`define SCUWP_ST_SL_LSB 8
`define SCUWP_ST_STATE_LSB 12

// State codes shown in the status register
`define SCUWP_STC_CMD0 3'h0
`define SCUWP_STC_CMD1 3'h1
`define SCUWP_STC_CMD2 3'h2
`define SCUWP_STC_CMD3 3'h3
`define SCUWP_STC_UNLOCK 3'h4

`endif

/* include/scuwp_if.sv */
/*
 * Register port between the on-chip core (host end) and the system control
 * unit (device end). Both ends run on the same clk_sys; no clocking block.
 */
`timescale 1ns/10ps
interface scuwp_if;
    logic [15:0] core_addr;
    logic [15:0] core_wdata;
    logic core_wr;
    logic core_rd;
    logic [15:0] core_rdata;
    logic core_rvalid;
    logic end_of_init;
    logic [15:0] periph_visible;

    modport dev (
        input core_addr,
        input core_wdata,
        input core_wr,
        input core_rd,
        input end_of_init,
        output core_rdata,
        output core_rvalid,
        output periph_visible
    );

    modport host (
        output core_addr,
        output core_wdata,
        output core_wr,
        output core_rd,
        output end_of_init,
        input core_rdata,
        input core_rvalid,
        input periph_visible
    );
endinterface

/* include/scuwp_pkg.sv */
/*
 * Types shared by both ends of the write protection block.
 * Assumes scuwp_consts.svh supplies all numeric constants.
 */
package scuwp_pkg;

    typedef enum logic [2:0] {
        SEQ_CMD0,
        SEQ_CMD1,
        SEQ_CMD2,
        SEQ_CMD3,
        SEQ_UNLOCKED
    } scuwp_seq_t;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_SET_LEVEL,
        OP_END_INIT
    } scuwp_op_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_STAT_RD,
        H_STAT_WAIT,
        H_WRITE,
        H_READ_WAIT,
        H_DONE
    } scuwp_host_t;

endpackage

/* tb/scuwp_asserts.sv */
/*
 * Checker for the register port between the core end and the system
 * control unit end. Assumes it is instantiated beside the interface and
 * sees its signals as plain inputs, on the one clk_sys domain.
 */
`timescale 1ns/10ps
`include "scuwp_consts.svh"

module scuwp_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Core side of the port
    input wire logic [15:0] core_addr,
    input wire logic [15:0] core_wdata,
    input wire logic core_wr,
    input wire logic core_rd,
    input wire logic end_of_init,
    // Unit side of the port
    input wire logic [15:0] core_rdata,
    input wire logic core_rvalid,
    input wire logic [15:0] periph_visible
);
    logic fresh_q;
    logic locked_q;
    logic vis_set_q;
    logic stat_rd;
    logic wr_cmd;
    logic wr_vis;
    logic mapped;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    assign stat_rd = core_rd && core_addr == `SCUWP_ADDR_STAT;
    assign wr_cmd = core_wr && core_addr == `SCUWP_ADDR_CMD;
    assign wr_vis = core_wr && core_addr == `SCUWP_ADDR_VIS;
    assign mapped = core_addr inside {`SCUWP_ADDR_VIS, `SCUWP_ADDR_CMD, `SCUWP_ADDR_STAT,
        `SCUWP_ADDR_CFG1, `SCUWP_ADDR_CFG2, `SCUWP_ADDR_CFG3};

    // No command write and no init end since reset: status must still be all zeros
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fresh_q <= 1'b1;
        end else if (end_of_init || wr_cmd) begin
            fresh_q <= 1'b0;
        end
    end

    // Init ended and no command written since
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            locked_q <= 1'b0;
        end else if (end_of_init) begin
            locked_q <= 1'b1;
        end else if (wr_cmd) begin
            locked_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vis_set_q <= 1'b0;
        end else if (wr_vis) begin
            vis_set_q <= 1'b1;
        end
    end

    AST_RVALID_AFTER_RD: assert property (core_rd |=> core_rvalid)
        else $error("read strobe not answered next cycle");
    AST_RVALID_CAUSE: assert property (core_rvalid |-> $past(core_rd))
        else $error("read valid without a read strobe");
    AST_RDATA_HOLD: assert property (!core_rd |=> $stable(core_rdata))
        else $error("read data moved without a read");
    AST_VIS_WRITE: assert property (wr_vis |=> periph_visible == $past(core_wdata))
        else $error("visibility enables differ from written word");
    AST_VIS_HOLD: assert property (!wr_vis |=> $stable(periph_visible))
        else $error("visibility enables changed without a write");
    AST_VIS_RESET: assert property (!vis_set_q |-> periph_visible == `SCUWP_VIS_RST)
        else $error("visibility enables not zero after reset");
    AST_LVL_RESET: assert property (stat_rd && fresh_q |=> core_rdata == `SCUWP_ZERO16)
        else $error("status not unprotected after reset");
    AST_LVL_END_OF_INIT_INSTRUCTION: assert property (stat_rd && locked_q |=>
        core_rdata[`SCUWP_ST_SL_LSB +: 2] == `SCUWP_SL_WPROT)
        else $error("level not write protected after init end");
    AST_LVL_CODE: assert property (stat_rd |=>
        core_rdata[`SCUWP_ST_SL_LSB +: 2] != `SCUWP_SL_RSVD)
        else $error("status shows reserved level code");
    AST_UNMAPPED: assert property (core_rd && !mapped |=> core_rdata == `SCUWP_ZERO16)
        else $error("unmapped read returned nonzero");
endmodule

/* tb/scuwp_tb.sv */
/*
 * Testbench: core end and unit end joined by the interface, driven through
 * the core end's user port. Assumes the package and header are compiled.
 */
`timescale 1ns/10ps
`include "scuwp_consts.svh"

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module scuwp_tb;
    logic clk_sys, rst, op_start, op_busy, op_done, op_refused;
    scuwp_pkg::scuwp_op_t op_kind;
    logic [15:0] op_addr, op_data, op_rdata, sys_cfg1, sys_cfg2, sys_cfg3;
    logic [1:0] op_level, security_level;
    logic [7:0] op_pwd;
    logic [2:0] cmd_state;
    int miscompares, comparisons, cycles, lat;

    scuwp_if bus();
    scuwp_device i_scuwp_device (.clk_sys(clk_sys), .rst(rst), .core(bus),
        .sys_cfg1(sys_cfg1), .sys_cfg2(sys_cfg2), .sys_cfg3(sys_cfg3),
        .security_level(security_level), .cmd_state(cmd_state));
    scuwp_core_host i_scuwp_core_host (.clk_sys(clk_sys), .rst(rst), .core(bus),
        .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
        .op_level(op_level), .op_pwd(op_pwd), .op_busy(op_busy), .op_done(op_done),
        .op_refused(op_refused), .op_rdata(op_rdata));
    scuwp_asserts i_scuwp_asserts (.clk_sys(clk_sys), .rst(rst), .core_addr(bus.core_addr),
        .core_wdata(bus.core_wdata), .core_wr(bus.core_wr), .core_rd(bus.core_rd),
        .end_of_init(bus.end_of_init), .core_rdata(bus.core_rdata),
        .core_rvalid(bus.core_rvalid), .periph_visible(bus.periph_visible));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            $display("[FAIL] t=%0t cycle ceiling reached", $time);
            results();
        end
    end

    task results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One user operation; lat counts edges from start edge to done
    task run_op(input scuwp_pkg::scuwp_op_t k, input logic [15:0] a, input logic [15:0] d,
        input logic [1:0] l, input logic [7:0] p);
        @(negedge clk_sys);
        op_start = 1'b1;
        op_kind = k;
        op_addr = a;
        op_data = d;
        op_level = l;
        op_pwd = p;
        @(negedge clk_sys);
        op_start = 1'b0;
        `CHK(op_busy, 1'b1)
        lat = 0;
        while (op_done !== 1'b1 && lat < 40) begin
            @(negedge clk_sys);
            lat++;
        end
        `CHK({op_done, op_busy}, 2'b10)
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d);
        run_op(scuwp_pkg::OP_WRITE, a, d, 2'h0, 8'h00);
    endtask

    task rd(input logic [15:0] a);
        run_op(scuwp_pkg::OP_READ, a, 16'h0000, 2'h0, 8'h00);
    endtask

    task t_reset;
        `CHK({sys_cfg1, sys_cfg2, sys_cfg3}, 48'h0000_0000_0000)
        `CHK(security_level, `SCUWP_SL_UNPROT)
        `CHK(bus.periph_visible, 16'h0000)
        rd(`SCUWP_ADDR_STAT);
        `CHK(op_rdata, 16'h0000)
        $display("t_reset finished");
    endtask

    task t_unprot;
        wr(`SCUWP_ADDR_CFG1, 16'h0e23);
        wr(`SCUWP_ADDR_CFG2, 16'h0e2f);
        wr(`SCUWP_ADDR_CFG3, 16'h0e2b);
        `CHK({sys_cfg1, sys_cfg2, sys_cfg3}, 48'h0e23_0e2f_0e2b)
        rd(`SCUWP_ADDR_CFG2);
        `CHK(op_rdata, 16'h0e2f)
        wr(`SCUWP_ADDR_VIS, 16'hffff);
        `CHK(op_refused, 1'b0)
        `CHK(bus.periph_visible, 16'h0020)
        wr(16'h1000, 16'hbeef);
        rd(16'h1000);
        `CHK(op_rdata, 16'h0000)
        rd(`SCUWP_ADDR_STAT);
        `CHK(op_rdata, 16'h0000)
        $display("t_unprot finished");
    endtask

    task t_low;
        run_op(scuwp_pkg::OP_SET_LEVEL, 16'h0000, 16'h0000, `SCUWP_SL_LOW, 8'h5a);
        `CHK(lat, 8)
        `CHK(security_level, `SCUWP_SL_LOW)
        rd(`SCUWP_ADDR_STAT);
        `CHK(op_rdata, 16'h015a)
        wr(`SCUWP_ADDR_CFG1, 16'h00a5);
        `CHK(lat, 6)
        `CHK(sys_cfg1, 16'h00a5)
        `CHK(security_level, `SCUWP_SL_LOW)
        // The state code output is registered one cycle behind the state
        @(negedge clk_sys);
        `CHK(cmd_state, `SCUWP_STC_CMD0)
        $display("t_low finished");
    endtask

    task t_lock;
        run_op(scuwp_pkg::OP_END_INIT, 16'h0000, 16'h0000, 2'h0, 8'h00);
        `CHK(security_level, `SCUWP_SL_WPROT)
        wr(`SCUWP_ADDR_CFG2, 16'h7777);
        `CHK(sys_cfg2, 16'h0e2f)
        rd(`SCUWP_ADDR_CFG2);
        `CHK(op_rdata, 16'h0e2f)
        wr(`SCUWP_ADDR_VIS, 16'h0000);
        `CHK(op_refused, 1'b1)
        `CHK(bus.periph_visible, 16'h0020)
        run_op(scuwp_pkg::OP_SET_LEVEL, 16'h0000, 16'h0000, `SCUWP_SL_RSVD, 8'h11);
        `CHK(security_level, `SCUWP_SL_WPROT)
        @(negedge clk_sys);
        `CHK(cmd_state, `SCUWP_STC_CMD0)
        rd(`SCUWP_ADDR_STAT);
        `CHK(op_rdata, 16'h035a)
        run_op(scuwp_pkg::OP_SET_LEVEL, 16'h0000, 16'h0000, `SCUWP_SL_UNPROT, 8'h3c);
        `CHK(security_level, `SCUWP_SL_UNPROT)
        wr(`SCUWP_ADDR_CFG3, 16'h4321);
        `CHK(sys_cfg3, 16'h4321)
        $display("t_lock finished");
    endtask

    initial begin
        rst = 1'b1;
        op_start = 1'b0;
        op_kind = scuwp_pkg::OP_READ;
        op_addr = 16'h0000;
        op_data = 16'h0000;
        op_level = 2'h0;
        op_pwd = 8'h00;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_unprot();
        t_low();
        t_lock();
        results();
    end
endmodule
